// *** pcnw_consts.svh ***
// Constants for the pin change notify and wake-up block
`ifndef PCNW_CONSTS_SVH
`define PCNW_CONSTS_SVH
`define PCNW_NUM_PINS      23
`define PCNW_LOW_WIDTH     16
`define PCNW_HIGH_WIDTH    7
`define PCNW_ENABLE_RESET  16'h0000
`endif

// *** pcnw_pkg.sv ***
// Types for the pin change notify and wake-up block
package pcnw_pkg;
  typedef enum logic [1:0] {
    PCNW_RUN,
    PCNW_IDLE,
    PCNW_SLEEP
  } pcnw_power_t;
endpackage

// *** pcnw_sync_if.sv ***
// Carrier between the top module and the pin synchroniser
`timescale 1ns/1ps
interface pcnw_sync_if #(
  parameter int N = 23
);
  logic [N-1:0] raw;
  logic [N-1:0] stable;
  modport top  (output raw, input stable);
  modport sync (input raw, output stable);
endinterface

// *** pcnw_sync.sv ***
// Three-stage synchroniser for the notification pins
`timescale 1ns/1ps
module pcnw_sync #(
  parameter int N = 23
) (
  input wire logic  clk_sys,
  input wire logic  rst_n,
  pcnw_sync_if.sync port_if
);
  logic [N-1:0] s1_reg;
  logic [N-1:0] s2_reg;
  logic [N-1:0] s3_reg;
  logic [N-1:0] stable_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= port_if.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stable_reg[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          stable_reg[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

  assign port_if.stable = stable_reg;
endmodule

// *** pcnw_top.sv ***
// Pin change notification, weak pull control and wake-up
// Contract
// - Raise interrupt request when any selected input pin changes state.
// - Detection keeps working in Sleep with the clock stopped.
// - Up to 23 individually selectable notification inputs.
// - Six enable registers: two irq, two pull-up, two pull-down.
// - Only pins with irq enable set can cause the notification.
// - Pull-up enable bit switches that pin's weak pull-up on or off.
// - Pull-down enable bit switches that pin's weak pull-down independently.
// - Sleep stops clocks and code; Idle halts CPU, peripherals run.
// - Leave Sleep or Idle on enabled interrupt, watchdog timeout or reset.
`timescale 1ns/1ps
`include "pcnw_consts.svh"
module pcnw_top #(
  parameter int N = `PCNW_NUM_PINS
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic [N-1:0]                 pin_in,
  input  wire logic [`PCNW_LOW_WIDTH-1:0]   change_irq_enable_low,
  input  wire logic [`PCNW_HIGH_WIDTH-1:0]  change_irq_enable_high,
  input  wire logic [`PCNW_LOW_WIDTH-1:0]   weak_pullup_enable_low,
  input  wire logic [`PCNW_HIGH_WIDTH-1:0]  weak_pullup_enable_high,
  input  wire logic [`PCNW_LOW_WIDTH-1:0]   weak_pulldown_enable_low,
  input  wire logic [`PCNW_HIGH_WIDTH-1:0]  weak_pulldown_enable_high,
  input  wire logic                         notice_clear,
  input  wire logic                         sleep_request,
  input  wire logic                         idle_request,
  input  wire logic                         other_irq,
  input  wire logic                         watchdog_timeout,
  output logic [N-1:0]                      pullup_on,
  output logic [N-1:0]                      pulldown_on,
  output logic                              pin_change_notice,
  output logic                              cpu_clk_en,
  output logic                              periph_clk_en,
  output logic                              in_sleep,
  output logic                              in_idle
);
  logic [N-1:0]        irq_en;
  logic [N-1:0]        last_reg;
  logic [N-1:0]        mismatch;
  logic                change_of_state;
  logic                asleep_wake_seen_reg;
  logic                wake_s1_reg;
  logic                wake_s2_reg;
  logic                wake_s3_reg;
  logic                wake_event;
  pcnw_pkg::pcnw_power_t power_reg;

  pcnw_sync_if #(.N(N)) sync_if ();

  assign sync_if.raw = pin_in;

  // Pins cross in through three flops and a hold register before the awake compare
  pcnw_sync #(.N(N)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .port_if (sync_if)
  );

  // Two enable words form one per-pin vector
  assign irq_en = N'({change_irq_enable_high, change_irq_enable_low});

  // Only enabled pins are compared against their last level; after reset the
  // last level is low, so a pin already high with its enable set gives one notice
  genvar b;
  generate
    for (b = 0; b < N; b++) begin : g_pin
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          last_reg[b] <= 1'b0;
        end else begin
          last_reg[b] <= sync_if.stable[b];
        end
      end
      assign mismatch[b] = (sync_if.stable[b] ^ last_reg[b]) & irq_en[b];
    end
  endgenerate

  assign change_of_state = |mismatch;

  // Sticky notice; a new change wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_change_notice <= 1'b0;
    end else if (change_of_state || wake_event) begin
      pin_change_notice <= 1'b1;
    end else if (notice_clear) begin
      pin_change_notice <= 1'b0;
    end
  end

  // Pull requests, one bit per pin in the same order as the irq enables
  logic [N-1:0] pu_req;
  logic [N-1:0] pd_req;
  assign pu_req = N'({weak_pullup_enable_high, weak_pullup_enable_low});
  assign pd_req = N'({weak_pulldown_enable_high, weak_pulldown_enable_low});

  // Each pin and each direction is registered on its own; both pulls on at
  // once is left to software, nothing here refuses it
  genvar q;
  generate
    for (q = 0; q < N; q++) begin : g_pull
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pullup_on[q]   <= 1'b0;
          pulldown_on[q] <= 1'b0;
        end else begin
          pullup_on[q]   <= pu_req[q];
          pulldown_on[q] <= pd_req[q];
        end
      end
    end
  endgenerate

  // Sleep path: the raw pins are compared with a level frozen on Sleep entry,
  // so a change is caught with no clock edge at all
  logic [N-1:0] sleep_ref_reg;
  logic         sleep_arm;
  assign sleep_arm = (power_reg == pcnw_pkg::PCNW_SLEEP);

  // Reference follows the stable pins while awake
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_ref_reg <= '0;
    end else if (!sleep_arm) begin
      sleep_ref_reg <= sync_if.stable;
    end
  end

  logic async_change;
  logic latch_clr_n;
  assign async_change = sleep_arm && (|((pin_in ^ sleep_ref_reg) & irq_en));
  // Held clear outside Sleep, so one wake cannot leak into the next Sleep
  assign latch_clr_n  = rst_n && sleep_arm;

  // The latch is clocked by the pin difference itself: no clock runs in Sleep
  always_ff @(posedge async_change or negedge latch_clr_n) begin
    if (!latch_clr_n) begin
      asleep_wake_seen_reg <= 1'b0;
    end else begin
      asleep_wake_seen_reg <= 1'b1;
    end
  end

  // Bring the wake level into the clock domain once clocks run
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
    end else if (!sleep_arm) begin
      // Flushed while awake; a stale level would end the next Sleep at once
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
    end else begin
      wake_s1_reg <= asleep_wake_seen_reg;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
    end
  end

  assign wake_event = wake_s2_reg && wake_s3_reg && sleep_arm;

  // Any enabled interrupt, a watchdog timeout or a pin change ends Sleep and Idle;
  // requests for Sleep or Idle are only taken while running
  logic wake_any;
  assign wake_any = change_of_state || wake_event || other_irq || watchdog_timeout;

  // Power state; wake sources end Sleep or Idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_reg <= pcnw_pkg::PCNW_RUN;
    end else begin
      case (power_reg)
        pcnw_pkg::PCNW_RUN: begin
          if (sleep_request) begin
            power_reg <= pcnw_pkg::PCNW_SLEEP;
          end else if (idle_request) begin
            power_reg <= pcnw_pkg::PCNW_IDLE;
          end
        end
        pcnw_pkg::PCNW_IDLE,
        pcnw_pkg::PCNW_SLEEP: begin
          if (wake_any) begin
            power_reg <= pcnw_pkg::PCNW_RUN;
          end
        end
        default: begin
          power_reg <= pcnw_pkg::PCNW_RUN;
        end
      endcase
    end
  end

  // Clock enables follow the power state one cycle late; in Idle only the
  // CPU stops, in Sleep both stop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
    end else begin
      cpu_clk_en    <= (power_reg == pcnw_pkg::PCNW_RUN);
      periph_clk_en <= (power_reg != pcnw_pkg::PCNW_SLEEP);
    end
  end

  // State indicators for the rest of the device
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_sleep <= 1'b0;
      in_idle  <= 1'b0;
    end else begin
      in_sleep <= (power_reg == pcnw_pkg::PCNW_SLEEP);
      in_idle  <= (power_reg == pcnw_pkg::PCNW_IDLE);
    end
  end
endmodule

// *** pcnw_props.sv ***
// Port assertions for the pin change notify block
`timescale 1ns/1ps
module pcnw_props #(
  parameter int N = 23
) (
  input logic          clk_sys,
  input logic          rst_n,
  input logic [N-1:0]  pin_in,
  input logic [15:0]   change_irq_enable_low,
  input logic [6:0]    change_irq_enable_high,
  input logic [15:0]   weak_pullup_enable_low,
  input logic [6:0]    weak_pullup_enable_high,
  input logic [15:0]   weak_pulldown_enable_low,
  input logic [6:0]    weak_pulldown_enable_high,
  input logic          notice_clear,
  input logic          watchdog_timeout,
  input logic [N-1:0]  pullup_on,
  input logic [N-1:0]  pulldown_on,
  input logic          pin_change_notice,
  input logic          cpu_clk_en,
  input logic          periph_clk_en,
  input logic          in_sleep,
  input logic          in_idle
);
  wire [N-1:0] irq_all = {change_irq_enable_high, change_irq_enable_low};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  pull_up_copy_a: assert property (1 |=> pullup_on == $past({weak_pullup_enable_high, weak_pullup_enable_low}))
    else $error("pull-up output does not follow its enable");
  pull_down_copy_a: assert property (1 |=> pulldown_on == $past({weak_pulldown_enable_high, weak_pulldown_enable_low}))
    else $error("pull-down output does not follow its enable");
  notice_sticky_a: assert property (pin_change_notice && !notice_clear |=> pin_change_notice)
    else $error("notice dropped without a clear");
  masked_quiet_a: assert property ((irq_all == 0) [*6] |-> !$rose(pin_change_notice))
    else $error("notice raised with every pin masked");
  change_seen_a: assert property (((pin_in ^ $past(pin_in)) & irq_all) != 0 |-> ##[1:8] pin_change_notice)
    else $error("enabled pin change gave no notice");
  sleep_clocks_a: assert property (in_sleep |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks running in sleep");
  idle_clocks_a: assert property (in_idle |-> !cpu_clk_en && periph_clk_en)
    else $error("wrong clock gating in idle");
  dog_wake_a: assert property (in_sleep && watchdog_timeout |-> ##[1:3] cpu_clk_en)
    else $error("watchdog timeout did not wake");
endmodule
bind pcnw_top pcnw_props #(.N(N)) pcnw_props_i (
  .clk_sys                   (clk_sys),
  .rst_n                     (rst_n),
  .pin_in                    (pin_in),
  .change_irq_enable_low     (change_irq_enable_low),
  .change_irq_enable_high    (change_irq_enable_high),
  .weak_pullup_enable_low    (weak_pullup_enable_low),
  .weak_pullup_enable_high   (weak_pullup_enable_high),
  .weak_pulldown_enable_low  (weak_pulldown_enable_low),
  .weak_pulldown_enable_high (weak_pulldown_enable_high),
  .notice_clear              (notice_clear),
  .watchdog_timeout          (watchdog_timeout),
  .pullup_on                 (pullup_on),
  .pulldown_on               (pulldown_on),
  .pin_change_notice         (pin_change_notice),
  .cpu_clk_en                (cpu_clk_en),
  .periph_clk_en             (periph_clk_en),
  .in_sleep                  (in_sleep),
  .in_idle                   (in_idle)
);

// *** pcnw_keypad.sv ***
// Keypad model: switches to the supply rail on the notification pins
`timescale 1ns/1ps
module pcnw_keypad #(
  parameter int N = 23
) (
  input logic          clk_sys,
  input logic [N-1:0]  press,
  input logic [N-1:0]  pullup_on,
  input logic [N-1:0]  pulldown_on,
  output logic [N-1:0] pin_in
);
  logic [N-1:0] drift_reg = '0;
  // Unpulled open pin wanders so a missing pull is not hidden
  always @(posedge clk_sys) drift_reg <= ~drift_reg;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_in[i] = press[i] | pullup_on[i] | (!pulldown_on[i] & drift_reg[i]);
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the pin change notify block
`timescale 1ns/1ps
module testbench;
  localparam int N = 23;
  logic clk_sys, rst_n, notice_clear, sleep_request, idle_request, other_irq, watchdog_timeout;
  logic [N-1:0] press, irq_en, pu_en, pd_en, pullup_on, pulldown_on, pin_in;
  logic pin_change_notice, cpu_clk_en, periph_clk_en, in_sleep, in_idle;
  logic [2*N+4:0] exp_q[$];
  int n_errors, num_checks, seed, k, p;
  event chk_ev;
  pcnw_top #(.N(N)) pcnw_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(pin_in),
    .change_irq_enable_low(irq_en[15:0]), .change_irq_enable_high(irq_en[22:16]),
    .weak_pullup_enable_low(pu_en[15:0]), .weak_pullup_enable_high(pu_en[22:16]),
    .weak_pulldown_enable_low(pd_en[15:0]), .weak_pulldown_enable_high(pd_en[22:16]),
    .notice_clear(notice_clear), .sleep_request(sleep_request), .idle_request(idle_request),
    .other_irq(other_irq), .watchdog_timeout(watchdog_timeout), .pullup_on(pullup_on),
    .pulldown_on(pulldown_on), .pin_change_notice(pin_change_notice), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .in_sleep(in_sleep), .in_idle(in_idle));
  pcnw_keypad #(.N(N)) pcnw_keypad_i (.clk_sys(clk_sys), .press(press), .pullup_on(pullup_on),
    .pulldown_on(pulldown_on), .pin_in(pin_in));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(chk_ev) begin
    num_checks++;
    if ({pullup_on, pulldown_on, in_idle, in_sleep, periph_clk_en, cpu_clk_en, pin_change_notice} !== exp_q[0]) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time,
        {pullup_on, pulldown_on, in_idle, in_sleep, periph_clk_en, cpu_clk_en, pin_change_notice}, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  task chk(input logic [4:0] st);
    exp_q.push_back({pu_en, pd_en, st});
    ->chk_ev;
  endtask
  task settle(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    settle(1);
    s = 1'b0;
  endtask
  task wait_notice;
    for (k = 0; k < 14 && pin_change_notice !== 1'b1; k++) settle(1);
    if (k == 14) begin
      n_errors++;
      wrap_up;
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    seed = 32'hE68EAD8E;
    {rst_n, notice_clear, sleep_request, idle_request, other_irq, watchdog_timeout} = '0;
    {press, irq_en, pu_en, pd_en} = '0;
    settle(8);
    rst_n = 1'b1;
    chk(5'h06);
    for (int i = 0; i < 4; i++) begin
      pu_en = N'($random(seed));
      pd_en = ~pu_en;
      settle(2);
      chk(5'h06);
    end
    pu_en = '0;
    pd_en = '1;
    settle(8);
    for (int j = 0; j < 5; j++) begin
      p = (j == 4) ? $unsigned($random(seed)) % N : (j == 0 ? 0 : j == 1 ? 15 : j == 2 ? 16 : 22);
      irq_en = N'(1) << p;
      press[(p + 1) % N] = 1'b1;
      settle(10);
      chk(5'h06);
      press = N'(1) << p;
      wait_notice;
      chk(5'h07);
      pulse(notice_clear);
      settle(2);
      chk(5'h06);
      press = '0;
      wait_notice;
      pulse(notice_clear);
      settle(2);
    end
    pulse(sleep_request);
    settle(3);
    chk(5'h08);
    press = N'(1) << p;
    wait_notice;
    settle(2);
    chk(5'h07);
    pulse(notice_clear);
    settle(2);
    pulse(sleep_request);
    settle(3);
    pulse(watchdog_timeout);
    settle(3);
    chk(5'h06);
    pulse(idle_request);
    settle(3);
    chk(5'h14);
    pulse(other_irq);
    settle(3);
    chk(5'h06);
    settle(2);
    wrap_up;
  end
endmodule
